//--- rtl/dac_pkg.sv
// Constants and types shared by the DMA arbiter/mode controller and the DMA-side unit.
// Assumes one 100 MHz system clock shared by both ends; the interface joins them.
package dac_pkg;
   // Register indices of the controller's own register port.
   localparam logic [3:0] DAC_REG_CTRL = 4'h0;
   localparam logic [3:0] DAC_REG_STATUS = 4'h1;
   localparam logic [3:0] DAC_REG_SWRESET = 4'h2;
   localparam logic [3:0] DAC_REG_PWRDOWN = 4'h3;
   localparam logic [3:0] DAC_REG_CAUSE = 4'h4;
   // Control register fields.
   localparam int DAC_CTRL_DMA_EN = 0;
   localparam int DAC_CTRL_PAR_EN = 1;
   localparam int DAC_CTRL_SESS_TO_EN = 2;
   localparam int DAC_CTRL_PD_ALLOW = 3;
   localparam int DAC_CTRL_ERR_HALT = 4;
   localparam logic [4:0] DAC_CTRL_RESET = 5'h05;
   // Reset cause encodings.
   localparam logic [1:0] DAC_CAUSE_COLD = 2'h0;
   localparam logic [1:0] DAC_CAUSE_SOFT = 2'h1;
   localparam logic [1:0] DAC_CAUSE_WDOG = 2'h2;
   localparam logic [1:0] DAC_CAUSE_ERR = 2'h3;
   // Timing figures in clocks and their counts.
   localparam int DAC_SESSION_CLOCKS = 1024;
   localparam logic [10:0] DAC_SESSION_CNT = 11'(DAC_SESSION_CLOCKS);
   localparam int DAC_RESET_EXT_CLOCKS = 16;
   localparam logic [4:0] DAC_RESET_EXT_CNT = 5'(DAC_RESET_EXT_CLOCKS);
   localparam int DAC_COLD_MIN_CLOCKS = 4;
   // Word size code the DMA unit must drive.
   localparam logic [1:0] DAC_SIZE_WORD = 2'h2;
   // Arbiter states.
   typedef enum logic [2:0] {
      DAC_ARB_CPU, DAC_ARB_HOLD, DAC_ARB_GRANT, DAC_ARB_EXC, DAC_ARB_REL
   } dac_arb_e;
endpackage : dac_pkg

//--- rtl/dac_link_if.sv
// Interface joining the DMA arbiter (device end) and the DMA unit (far end).
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface dac_link_if;
   logic dma_bus_request_n;
   logic dma_bus_grant_n;
   logic dma_address_strobe;
   logic [31:0] addr;
   logic [3:0] access_space_id;
   logic [1:0] size;
   logic write_early;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic data_parity_out;
   logic data_parity_in;
   logic dma_data_ready_n;
   logic memory_exception_n;
   modport device (input dma_bus_request_n, dma_address_strobe, addr, access_space_id, size,
      write_early, wdata, data_parity_out,
      output dma_bus_grant_n, rdata, data_parity_in, dma_data_ready_n, memory_exception_n);
   modport dma (output dma_bus_request_n, dma_address_strobe, addr, access_space_id, size,
      write_early, wdata, data_parity_out,
      input dma_bus_grant_n, rdata, data_parity_in, dma_data_ready_n, memory_exception_n);
endinterface : dac_link_if

//--- rtl/dac_arbiter.sv
// Device end: DMA bus arbiter, execution-mode sequencer and its register port.
// Assumes memory-side status (ready, errors, protection verdicts) arrives from
// logic on core_clk; the cold reset, halt, request and strobe pins are synchronised here.
`timescale 1ns/1ps
module dac_arbiter
   import dac_pkg::*;
(
   // Clock and cold reset.
   input wire logic core_clk,
   input wire logic rst,
   input wire logic cold_reset_in_n,
   // DMA link.
   dac_link_if.device lnk,
   // Register port.
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Processor side.
   input wire logic cpu_cycle_busy,
   input wire logic cpu_locked,
   input wire logic cpu_error_n,
   input wire logic ext_interrupt,
   input wire logic system_halt_in_n,
   output logic cpu_bus_hold_n,
   output logic cpu_addr_out_en_n,
   output logic cpu_ctrl_out_en_n,
   output logic cpu_data_out_en_n,
   output logic processor_halt_n,
   output logic system_error_n,
   output logic reset_out_n,
   output logic timers_stop,
   // Memory side.
   input wire logic mem_ready,
   input wire logic mem_error,
   input wire logic mem_bus_timeout,
   input wire logic mem_write_violation,
   input wire logic mem_is_register,
   input wire logic [31:0] mem_rdata,
   input wire logic hw_error,
   input wire logic watchdog_timeout,
   output logic mem_start,
   output logic mem_supervisor,
   output logic mem_parity_gen
);
   typedef struct packed {
      logic [1:0] cold_sync;
      logic [1:0] halt_sync;
      logic [1:0] req_sync;
      logic [1:0] as_sync;
      logic cold_seen;
      logic [4:0] rst_cnt;
      logic [1:0] cause;
      logic [4:0] ctrl;
      logic pwr_down;
      logic err_halt;
      logic post_exc;
      dac_arb_e arb;
      logic [10:0] sess_cnt;
      logic in_access;
      logic grant_n;
      logic dma_data_ready_n_n;
      logic memory_exception_n_n;
      logic hold_n;
      logic [31:0] rdata;
      logic par_in;
      logic [31:0] reg_rdata;
      logic start;
      logic sup;
      logic pgen;
      logic oe_n;
      logic phalt_n;
      logic serr_n;
      logic tstop;
      logic rst_out_n;
   } dac_arb_s;
   dac_arb_s st_r, st_nxt;
   logic req, strobe, cold_low, sys_halted, any_halt, soft_rst;
   // Second stages of the pin synchronisers feed all logic.
   always_comb begin
      req = ~st_r.req_sync[1];
      strobe = st_r.as_sync[1];
      cold_low = ~st_r.cold_sync[1];
      sys_halted = ~st_r.halt_sync[1];
      any_halt = sys_halted | st_r.err_halt | st_r.pwr_down;
      soft_rst = reg_wr && reg_addr == DAC_REG_SWRESET;
   end
   // Next-state logic for modes, arbitration, access handling and registers.
   always_comb begin
      st_nxt = st_r;
      st_nxt.cold_sync = {st_r.cold_sync[0], cold_reset_in_n};
      st_nxt.halt_sync = {st_r.halt_sync[0], system_halt_in_n};
      st_nxt.req_sync = {st_r.req_sync[0], lnk.dma_bus_request_n};
      st_nxt.as_sync = {st_r.as_sync[0], lnk.dma_address_strobe};
      st_nxt.start = 1'b0;
      st_nxt.dma_data_ready_n_n = 1'b1;
      st_nxt.memory_exception_n_n = 1'b1;
      st_nxt.reg_rdata = 32'h0000_0000;
      if (st_r.rst_cnt != 5'h00) begin
         st_nxt.rst_cnt = st_r.rst_cnt - 5'h01;
      end
      // Register port reads.
      if (reg_rd) begin
         case (reg_addr)
            DAC_REG_CTRL: st_nxt.reg_rdata = {27'h0, st_r.ctrl};
            DAC_REG_STATUS: st_nxt.reg_rdata = {26'h0, st_r.arb == DAC_ARB_GRANT,
               st_r.pwr_down, st_r.err_halt, sys_halted, st_r.post_exc, ~st_r.grant_n};
            DAC_REG_CAUSE: st_nxt.reg_rdata = {30'h0, st_r.cause};
            default: st_nxt.reg_rdata = 32'h0000_0000;
         endcase
      end
      if (reg_wr && reg_addr == DAC_REG_CTRL) begin
         st_nxt.ctrl = reg_wdata[4:0];
      end
      if (reg_wr && reg_addr == DAC_REG_PWRDOWN && st_r.ctrl[DAC_CTRL_PD_ALLOW]) begin
         st_nxt.pwr_down = 1'b1;
      end
      if (st_r.pwr_down && ext_interrupt) begin
         st_nxt.pwr_down = 1'b0;
      end
      if ((hw_error && st_r.ctrl[DAC_CTRL_ERR_HALT]) || !cpu_error_n) begin
         st_nxt.err_halt = 1'b1;
      end
      // Arbitration.
      st_nxt.hold_n = ~st_nxt.pwr_down;
      case (st_r.arb)
         DAC_ARB_CPU: begin
            st_nxt.grant_n = 1'b1;
            if (req && any_halt) begin
               st_nxt.grant_n = 1'b0;
               st_nxt.arb = DAC_ARB_GRANT;
               st_nxt.sess_cnt = 11'h000;
            end else if (req && st_r.ctrl[DAC_CTRL_DMA_EN] && !cpu_cycle_busy
                  && !cpu_locked && !st_r.post_exc) begin
               st_nxt.hold_n = 1'b0;
               st_nxt.arb = DAC_ARB_HOLD;
            end
            if (!cpu_cycle_busy) begin
               st_nxt.post_exc = 1'b0;
            end
         end
         DAC_ARB_HOLD: begin
            st_nxt.hold_n = 1'b0;
            st_nxt.grant_n = 1'b0;
            st_nxt.arb = DAC_ARB_GRANT;
            st_nxt.sess_cnt = 11'h000;
         end
         DAC_ARB_GRANT: begin
            st_nxt.hold_n = 1'b0;
            if (st_r.sess_cnt != DAC_SESSION_CNT) begin
               st_nxt.sess_cnt = st_r.sess_cnt + 11'h001;
            end
            if (!req && !st_r.in_access) begin
               st_nxt.grant_n = 1'b1;
               st_nxt.arb = DAC_ARB_REL;
            end else if (st_r.ctrl[DAC_CTRL_SESS_TO_EN]
                  && st_r.sess_cnt == DAC_SESSION_CNT - 11'h001) begin
               st_nxt.memory_exception_n_n = 1'b0;
               st_nxt.grant_n = 1'b1;
               st_nxt.in_access = 1'b0;
               st_nxt.arb = DAC_ARB_EXC;
            end else if (!st_r.in_access && strobe) begin
               st_nxt.in_access = 1'b1;
               st_nxt.start = 1'b1;
               st_nxt.sup = mem_is_register ? sys_halted | st_r.err_halt
                  : lnk.access_space_id[0];
               st_nxt.pgen = lnk.write_early && !st_r.ctrl[DAC_CTRL_PAR_EN];
            end else if (st_r.in_access) begin
               if (mem_bus_timeout) begin
                  st_nxt.memory_exception_n_n = 1'b0;
                  st_nxt.grant_n = 1'b1;
                  st_nxt.in_access = 1'b0;
                  st_nxt.arb = DAC_ARB_EXC;
               end else if (mem_error || mem_write_violation) begin
                  st_nxt.memory_exception_n_n = 1'b0;
                  st_nxt.in_access = 1'b0;
                  st_nxt.post_exc = 1'b1;
               end else if (mem_ready) begin
                  st_nxt.dma_data_ready_n_n = 1'b0;
                  st_nxt.rdata = mem_rdata;
                  st_nxt.par_in = ~^mem_rdata;
                  st_nxt.in_access = 1'b0;
               end
            end
         end
         DAC_ARB_EXC: begin
            st_nxt.post_exc = 1'b1;
            st_nxt.arb = DAC_ARB_REL;
         end
         DAC_ARB_REL: begin
            st_nxt.grant_n = 1'b1;
            if (!req) begin
               st_nxt.arb = DAC_ARB_CPU;
            end
         end
         default: st_nxt.arb = DAC_ARB_CPU;
      endcase
      // Cold reset keeps the block cleared; other resets reload ctrl, clear power-down and post-exception and record their cause.
      if (cold_low) begin
         st_nxt = '0;
         st_nxt.cold_sync = {st_r.cold_sync[0], cold_reset_in_n};
         // Synchronisers keep sampling so no false request or halt follows release.
         st_nxt.halt_sync = {st_r.halt_sync[0], system_halt_in_n};
         st_nxt.req_sync = {st_r.req_sync[0], lnk.dma_bus_request_n};
         st_nxt.as_sync = {st_r.as_sync[0], lnk.dma_address_strobe};
         st_nxt.ctrl = DAC_CTRL_RESET;
         st_nxt.arb = DAC_ARB_CPU;
         st_nxt.grant_n = 1'b1;
         st_nxt.dma_data_ready_n_n = 1'b1;
         st_nxt.memory_exception_n_n = 1'b1;
         st_nxt.hold_n = 1'b1;
         st_nxt.cause = DAC_CAUSE_COLD;
         st_nxt.rst_cnt = DAC_RESET_EXT_CNT;
      end else if (soft_rst || watchdog_timeout
            || (hw_error && !st_r.ctrl[DAC_CTRL_ERR_HALT])) begin
         st_nxt.ctrl = DAC_CTRL_RESET;
         st_nxt.pwr_down = 1'b0;
         st_nxt.post_exc = 1'b0;
         st_nxt.cause = soft_rst ? DAC_CAUSE_SOFT
            : (watchdog_timeout ? DAC_CAUSE_WDOG : DAC_CAUSE_ERR);
         st_nxt.rst_cnt = DAC_RESET_EXT_CNT;
      end
      // Derived outputs are registered so that every output leaves a flip-flop.
      st_nxt.oe_n = ~st_nxt.hold_n;
      st_nxt.phalt_n = ~(sys_halted || st_nxt.err_halt);
      st_nxt.serr_n = ~st_nxt.err_halt;
      st_nxt.tstop = sys_halted || st_nxt.err_halt;
      st_nxt.rst_out_n = st_nxt.rst_cnt == 5'h00;
   end
   // State register.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
         st_r.cold_sync <= 2'h3;
         st_r.halt_sync <= 2'h3;
         st_r.req_sync <= 2'h3;
         st_r.ctrl <= DAC_CTRL_RESET;
         st_r.arb <= DAC_ARB_CPU;
         st_r.grant_n <= 1'b1;
         st_r.dma_data_ready_n_n <= 1'b1;
         st_r.memory_exception_n_n <= 1'b1;
         st_r.hold_n <= 1'b1;
         st_r.rst_cnt <= DAC_RESET_EXT_CNT;
         st_r.phalt_n <= 1'b1;
         st_r.serr_n <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end
   // Outputs come straight from the state register.
   assign lnk.dma_bus_grant_n = st_r.grant_n;
   assign lnk.dma_data_ready_n = st_r.dma_data_ready_n_n;
   assign lnk.memory_exception_n = st_r.memory_exception_n_n;
   assign lnk.rdata = st_r.rdata;
   assign lnk.data_parity_in = st_r.par_in;
   assign reg_rdata = st_r.reg_rdata;
   assign cpu_bus_hold_n = st_r.hold_n;
   assign cpu_addr_out_en_n = st_r.oe_n;
   assign cpu_ctrl_out_en_n = st_r.oe_n;
   assign cpu_data_out_en_n = st_r.oe_n;
   assign processor_halt_n = st_r.phalt_n;
   assign system_error_n = st_r.serr_n;
   assign timers_stop = st_r.tstop;
   assign reset_out_n = st_r.rst_out_n;
   assign mem_start = st_r.start;
   assign mem_supervisor = st_r.sup;
   assign mem_parity_gen = st_r.pgen;
endmodule : dac_arbiter

//--- rtl/dac_dma_unit.sv
// Far end: a DMA unit issuing single word transfers through the arbiter.
// Assumes the same system clock as the arbiter; user side gives one-cycle commands.
`timescale 1ns/1ps
module dac_dma_unit
   import dac_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // DMA link.
   dac_link_if.dma lnk,
   // User command side.
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [31:0] cmd_addr,
   input wire logic [31:0] cmd_wdata,
   input wire logic [3:0] cmd_space,
   input wire logic cmd_parity_en,
   output logic busy,
   output logic done,
   output logic failed,
   output logic [31:0] rdata
);
   typedef enum logic [2:0] {DAC_DMA_IDLE, DAC_DMA_REQ, DAC_DMA_STROBE, DAC_DMA_WAIT,
      DAC_DMA_END} dac_dma_e;
   typedef struct packed {
      dac_dma_e ph;
      logic req_n;
      logic as;
      logic wr;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0] space;
      logic par;
      logic busy;
      logic done;
      logic failed;
      logic [31:0] rdata;
   } dac_dma_s;
   dac_dma_s st_r, st_nxt;
   // Sequence: request, wait grant, strobe, wait ready or exception, release.
   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      st_nxt.failed = 1'b0;
      st_nxt.as = 1'b0;
      case (st_r.ph)
         DAC_DMA_IDLE: begin
            if (cmd_valid) begin
               st_nxt.req_n = 1'b0;
               st_nxt.wr = cmd_write;
               st_nxt.addr = cmd_addr;
               st_nxt.wdata = cmd_wdata;
               st_nxt.space = cmd_space;
               st_nxt.par = cmd_parity_en ? ~^cmd_wdata : 1'b0;
               st_nxt.busy = 1'b1;
               st_nxt.ph = DAC_DMA_REQ;
            end
         end
         DAC_DMA_REQ: begin
            if (!lnk.dma_bus_grant_n) begin
               st_nxt.as = 1'b1;
               st_nxt.ph = DAC_DMA_STROBE;
            end
         end
         DAC_DMA_STROBE: begin
            st_nxt.as = 1'b1;
            st_nxt.ph = DAC_DMA_WAIT;
         end
         DAC_DMA_WAIT: begin
            if (!lnk.memory_exception_n) begin
               st_nxt.req_n = 1'b1;
               st_nxt.failed = 1'b1;
               st_nxt.ph = DAC_DMA_END;
            end else if (!lnk.dma_data_ready_n) begin
               st_nxt.rdata = lnk.rdata;
               st_nxt.req_n = 1'b1;
               st_nxt.done = 1'b1;
               st_nxt.ph = DAC_DMA_END;
            end
         end
         DAC_DMA_END: begin
            if (lnk.dma_bus_grant_n) begin
               st_nxt.busy = 1'b0;
               st_nxt.ph = DAC_DMA_IDLE;
            end
         end
         default: st_nxt.ph = DAC_DMA_IDLE;
      endcase
   end
   // State register.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
         st_r.ph <= DAC_DMA_IDLE;
         st_r.req_n <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end
   // Link drive; only word transfers are issued.
   assign lnk.dma_bus_request_n = st_r.req_n;
   assign lnk.dma_address_strobe = st_r.as;
   assign lnk.addr = st_r.addr;
   assign lnk.access_space_id = st_r.space;
   assign lnk.size = DAC_SIZE_WORD;
   assign lnk.write_early = st_r.wr;
   assign lnk.wdata = st_r.wdata;
   assign lnk.data_parity_out = st_r.par;
   assign busy = st_r.busy;
   assign done = st_r.done;
   assign failed = st_r.failed;
   assign rdata = st_r.rdata;
endmodule : dac_dma_unit

//--- tb/dac_link_checker.sv
// Checker for the DMA link between the arbiter and the DMA unit.
// Assumes one clock and the asynchronous active-high reset of the design.
`timescale 1ns/1ps
module dac_link_checker
   import dac_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // Link signals.
   input wire logic dma_bus_request_n,
   input wire logic dma_bus_grant_n,
   input wire logic dma_address_strobe,
   input wire logic [1:0] size,
   input wire logic dma_data_ready_n,
   input wire logic memory_exception_n
);
   logic [10:0] grant_len_r;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // Counts how long the grant has been held, saturating at the top.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         grant_len_r <= 11'h000;
      end else if (dma_bus_grant_n) begin
         grant_len_r <= 11'h000;
      end else if (grant_len_r != 11'h7FF) begin
         grant_len_r <= grant_len_r + 11'h001;
      end
   end

   // Steps of a DMA session seen on the link.
   sequence s_grant_start;
      $fell(dma_bus_grant_n);
   endsequence
   sequence s_answer;
      !dma_data_ready_n || !memory_exception_n;
   endsequence
   sequence s_req_drop;
      $rose(dma_bus_request_n);
   endsequence

   a_grant_needs_req: assert property (s_grant_start |-> !$past(dma_bus_request_n, 2))
      else $error("grant given without a pending request");
   a_strobe_when_granted: assert property (dma_address_strobe |-> !dma_bus_grant_n)
      else $error("address strobe while the bus is not granted");
   a_word_size_only: assert property (dma_address_strobe |-> size == DAC_SIZE_WORD)
      else $error("size code is not a word during a transfer");
   a_answer_granted: assert property (s_answer |-> !$past(dma_bus_grant_n))
      else $error("answer on the link outside a granted session");
   a_ready_one_cycle: assert property (!dma_data_ready_n |=> dma_data_ready_n)
      else $error("data ready longer than one cycle");
   a_answer_exclusive: assert property (!(!dma_data_ready_n && !memory_exception_n))
      else $error("data ready and exception together");
   a_exc_one_cycle: assert property (!memory_exception_n |=> memory_exception_n)
      else $error("exception longer than one cycle");
   a_grant_release: assert property (s_req_drop |-> ##[1:6] dma_bus_grant_n)
      else $error("grant kept after the request was dropped");
   a_session_cap: assert property (grant_len_r <= 11'h406)
      else $error("grant held past the session limit");
endmodule : dac_link_checker

//--- tb/testbench.sv
// Self-checking bench: arbiter and DMA unit joined by the link interface.
// Assumes a 100 MHz clock; the bench plays the processor and the memory side.
`timescale 1ns/1ps
module testbench;
   import dac_pkg::*;
   logic core_clk = 1'b0, rst = 1'b1, cold_reset_in_n = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, mem_rdata = 32'h0, dma_rdata;
   logic reg_wr = 1'b0, reg_rd = 1'b0, cpu_cycle_busy = 1'b0, cpu_locked = 1'b0;
   logic cpu_error_n = 1'b1, ext_interrupt = 1'b0, system_halt_in_n = 1'b1;
   logic mem_ready = 1'b0, mem_error = 1'b0, mem_bus_timeout = 1'b0, mem_write_violation = 1'b0;
   logic mem_is_register = 1'b0, hw_error = 1'b0, watchdog_timeout = 1'b0;
   logic cpu_bus_hold_n, cpu_addr_out_en_n, cpu_ctrl_out_en_n, cpu_data_out_en_n;
   logic processor_halt_n, system_error_n, reset_out_n, timers_stop;
   logic mem_start, mem_supervisor, mem_parity_gen, busy, done, failed;
   logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_parity_en = 1'b0;
   logic [31:0] cmd_addr = 32'h0, cmd_wdata = 32'h0;
   logic [3:0] cmd_space = 4'h0, resp = 4'h1;
   logic [1:0] mwait = 2'h0;
   logic msup, mpar, g_prev = 1'b1, hold_seen, oe_seen;
   int n_mismatch = 0, tests_run = 0, lat = 0, lat_g = 0, gl = 0, glen = 0;

   dac_link_if lnk();
   dac_arbiter u_dac_arbiter (.core_clk(core_clk), .rst(rst), .cold_reset_in_n(cold_reset_in_n),
      .lnk(lnk.device), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_cycle_busy(cpu_cycle_busy),
      .cpu_locked(cpu_locked), .cpu_error_n(cpu_error_n), .ext_interrupt(ext_interrupt),
      .system_halt_in_n(system_halt_in_n), .cpu_bus_hold_n(cpu_bus_hold_n),
      .cpu_addr_out_en_n(cpu_addr_out_en_n), .cpu_ctrl_out_en_n(cpu_ctrl_out_en_n),
      .cpu_data_out_en_n(cpu_data_out_en_n), .processor_halt_n(processor_halt_n),
      .system_error_n(system_error_n), .reset_out_n(reset_out_n), .timers_stop(timers_stop),
      .mem_ready(mem_ready), .mem_error(mem_error), .mem_bus_timeout(mem_bus_timeout),
      .mem_write_violation(mem_write_violation), .mem_is_register(mem_is_register),
      .mem_rdata(mem_rdata), .hw_error(hw_error), .watchdog_timeout(watchdog_timeout),
      .mem_start(mem_start), .mem_supervisor(mem_supervisor), .mem_parity_gen(mem_parity_gen));
   dac_dma_unit u_dac_dma_unit (.core_clk(core_clk), .rst(rst), .lnk(lnk.dma),
      .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .cmd_space(cmd_space), .cmd_parity_en(cmd_parity_en), .busy(busy), .done(done),
      .failed(failed), .rdata(dma_rdata));
   dac_link_checker u_dac_link_checker (.core_clk(core_clk), .rst(rst),
      .dma_bus_request_n(lnk.dma_bus_request_n), .dma_bus_grant_n(lnk.dma_bus_grant_n),
      .dma_address_strobe(lnk.dma_address_strobe), .size(lnk.size),
      .dma_data_ready_n(lnk.dma_data_ready_n), .memory_exception_n(lnk.memory_exception_n));

   // Free-running 100 MHz clock.
   always #5 core_clk = ~core_clk;

   // Memory model: answers three cycles after each start with the one-hot code in resp.
   always @(posedge core_clk) begin
      {mem_write_violation, mem_bus_timeout, mem_error, mem_ready} <= 4'h0;
      mem_rdata <= ~lnk.addr;
      if (mem_start) begin
         msup <= mem_supervisor;
         mpar <= mem_parity_gen;
         mwait <= 2'h2;
      end else if (mwait != 2'h0) begin
         mwait <= mwait - 2'h1;
         if (mwait == 2'h1) {mem_write_violation, mem_bus_timeout, mem_error, mem_ready} <= resp;
      end
   end

   // Measures request-to-grant latency, the hold state at grant and the session length.
   always @(posedge core_clk) begin
      g_prev <= lnk.dma_bus_grant_n;
      lat <= lnk.dma_bus_request_n ? 0 : (lnk.dma_bus_grant_n ? lat + 1 : lat);
      gl <= lnk.dma_bus_grant_n ? 0 : gl + 1;
      if (!lnk.dma_bus_grant_n && g_prev) begin
         hold_seen <= cpu_bus_hold_n;
         oe_seen <= cpu_addr_out_en_n;
         lat_g <= lat;
      end
      if (lnk.dma_bus_grant_n && !g_prev) glen <= gl;
   end

   // Compares one value and counts the outcome.
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Register port write and read.
   task wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask : rd

   // Issues one DMA command; fin then waits for its completion.
   task issue(input logic w, input logic [31:0] a, input logic [3:0] sp, input logic pe);
      @(posedge core_clk);
      {cmd_valid, cmd_write, cmd_addr, cmd_wdata, cmd_space} <= {1'b1, w, a, ~a, sp};
      cmd_parity_en <= pe;
      @(posedge core_clk);
      cmd_valid <= 1'b0;
   endtask : issue
   task fin(output logic ok);
      int k;
      k = 0;
      ok = 1'b0;
      while (k < 2000) begin
         @(posedge core_clk);
         #1;
         if (done === 1'b1 || failed === 1'b1) begin
            ok = done;
            k = 2000;
         end else k++;
      end
      // Waits for the unit to return to idle so that the next command is not lost.
      while (busy === 1'b1 && k < 4000) begin
         @(posedge core_clk);
         #1 k++;
      end
   endtask : fin

   // Pulses one control input for a cycle.
   task pulse(input int which);
      @(posedge core_clk);
      if (which == 1) watchdog_timeout <= 1'b1; else hw_error <= 1'b1;
      @(posedge core_clk);
      {watchdog_timeout, hw_error} <= 2'h0;
   endtask : pulse

   // Prints the verdict and ends the run.
   task wrap_up();
      if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   // Cuts a hang short.
   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      wrap_up();
   end

   // Main sequence.
   initial begin
      int i, n, lr;
      logic ok;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      repeat (30) @(posedge core_clk);
      rd(DAC_REG_CTRL, 32'h5);
      rd(4'hF, 32'h0);
      issue(1'b1, 32'h0200_0040, 4'hB, 1'b0);
      fin(ok);
      chk(ok, 1);
      chk({hold_seen, oe_seen, mpar}, 3'b011);
      lr = lat_g;
      issue(1'b0, 32'h0200_0040, 4'hA, 1'b0);
      fin(ok);
      chk(dma_rdata, 32'hFDFF_FFBF);
      repeat (6) @(posedge core_clk);
      chk({lnk.dma_bus_grant_n, cpu_bus_hold_n}, 2'b11);
      wr(DAC_REG_CTRL, 32'h7);
      issue(1'b1, 32'h0200_0080, 4'hB, 1'b1);
      fin(ok);
      chk(mpar, 0);
      for (i = 1; i < 4; i++) begin
         resp = 4'h1 << i;
         issue(1'b1, 32'h0200_0100, 4'hA, 1'b0);
         fin(ok);
         chk(ok, 0);
         repeat (6) @(posedge core_clk);
         chk(lnk.dma_bus_grant_n, 1);
      end
      resp = 4'h1;
      for (i = 0; i < 3; i++) begin
         if (i == 0) cpu_cycle_busy <= 1'b1;
         else if (i == 1) cpu_locked <= 1'b1;
         else wr(DAC_REG_CTRL, 32'h4);
         issue(1'b0, 32'h0200_0200, 4'hB, 1'b0);
         repeat (20) @(posedge core_clk);
         chk(lnk.dma_bus_grant_n, 1);
         {cpu_cycle_busy, cpu_locked} <= 2'h0;
         wr(DAC_REG_CTRL, 32'h5);
         fin(ok);
         chk(ok, 1);
      end
      resp = 4'h0;
      issue(1'b0, 32'h0200_0300, 4'hB, 1'b0);
      fin(ok);
      chk({ok, 31'(glen >= 1023 && glen <= 1028)}, 32'h1);
      resp = 4'h1;
      mem_is_register <= 1'b1;
      issue(1'b0, 32'h01F8_0000, 4'h0, 1'b0);
      fin(ok);
      chk(msup, 0);
      system_halt_in_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk({processor_halt_n, timers_stop}, 2'b01);
      issue(1'b0, 32'h01F8_0000, 4'h0, 1'b0);
      fin(ok);
      chk({msup, 31'(lat_g < lr)}, {1'b1, 31'h1});
      system_halt_in_n <= 1'b1;
      mem_is_register <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk({processor_halt_n, timers_stop}, 2'b10);
      wr(DAC_REG_PWRDOWN, 32'h0);
      repeat (3) @(posedge core_clk);
      chk(cpu_bus_hold_n, 1);
      wr(DAC_REG_CTRL, 32'hD);
      wr(DAC_REG_PWRDOWN, 32'h0);
      repeat (3) @(posedge core_clk);
      chk({cpu_bus_hold_n, cpu_addr_out_en_n, cpu_ctrl_out_en_n, cpu_data_out_en_n},
         4'h7);
      issue(1'b0, 32'h0200_0400, 4'hB, 1'b0);
      fin(ok);
      chk({ok, 31'(lat_g < lr)}, {1'b1, 31'h1});
      chk(cpu_bus_hold_n, 0);
      @(posedge core_clk);
      ext_interrupt <= 1'b1;
      @(posedge core_clk);
      ext_interrupt <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk({cpu_bus_hold_n, cpu_addr_out_en_n, cpu_ctrl_out_en_n, cpu_data_out_en_n},
         4'h8);
      for (i = 0; i < 3; i++) begin
         wr(DAC_REG_CTRL, 32'hD);
         if (i == 0) wr(DAC_REG_SWRESET, 32'h1); else pulse(i);
         repeat (40) @(posedge core_clk);
         rd(DAC_REG_CAUSE, (i == 0) ? 32'(DAC_CAUSE_SOFT)
            : (i == 1) ? 32'(DAC_CAUSE_WDOG) : 32'(DAC_CAUSE_ERR));
         rd(DAC_REG_CTRL, 32'h5);
      end
      wr(DAC_REG_CTRL, 32'h15);
      pulse(2);
      repeat (4) @(posedge core_clk);
      chk({processor_halt_n, system_error_n, timers_stop}, 3'b001);
      issue(1'b0, 32'h0200_0500, 4'hB, 1'b0);
      fin(ok);
      chk({ok, 31'(lat_g < lr)}, {1'b1, 31'h1});
      wr(DAC_REG_SWRESET, 32'h1);
      repeat (40) @(posedge core_clk);
      chk(processor_halt_n, 0);
      cold_reset_in_n <= 1'b0;
      repeat (DAC_COLD_MIN_CLOCKS + 2) @(posedge core_clk);
      #1 chk(reset_out_n, 0);
      @(posedge core_clk);
      cold_reset_in_n <= 1'b1;
      n = 0;
      while (reset_out_n !== 1'b1 && n < 100) begin
         @(posedge core_clk);
         #1 n++;
      end
      chk(n >= DAC_RESET_EXT_CLOCKS && n <= DAC_RESET_EXT_CLOCKS + 4, 1);
      chk({processor_halt_n, system_error_n}, 2'b11);
      rd(DAC_REG_CAUSE, 32'(DAC_CAUSE_COLD));
      wrap_up();
   end
endmodule : testbench
